/* core/stms_cfg.svh */
// Constants for the starter mode sequencer
`ifndef STMS_CFG_SVH
`define STMS_CFG_SVH
// Register byte offsets
`define STMS_ADDR_CTRL      12'h000
`define STMS_ADDR_SPEED_TIME 12'h004
`define STMS_ADDR_FB_TIME   12'h008
`define STMS_ADDR_FLC       12'h00C
`define STMS_ADDR_AIN_CAL   12'h010
`define STMS_ADDR_MEAS      12'h014
`define STMS_ADDR_STATUS    12'h018
`define STMS_ADDR_REF       12'h01C
// Control field positions
`define STMS_CTRL_MODE_LSB  0
`define STMS_CTRL_FB_EN     2
`define STMS_CTRL_FB_CFG    3
`define STMS_CTRL_ONE_PHASE 4
// Transition thresholds in percent
`define STMS_CUR_PCT        85
`define STMS_TIME_PCT       25
// Timer tick: 1 ms at 200 MHz
`define STMS_TICK_NS        1000000
`define STMS_CLK_NS         5
`define STMS_TICK_CYC       (`STMS_TICK_NS / `STMS_CLK_NS)
// Reset values
`define STMS_SPEED_TIME_RST 16'h2710
`define STMS_FB_TIME_RST    16'h01F4
`define STMS_SPAN_RST       16'h0400
`endif

/* core/stms_pkg.sv */
// Types for the starter mode sequencer
package stms_pkg;
   typedef enum logic [1:0] {
      STMS_MODE_WYE_DELTA  = 2'b00,
      STMS_MODE_ACROSS     = 2'b01,
      STMS_MODE_PHASE      = 2'b10,
      STMS_MODE_SOFT       = 2'b11
   } stms_mode_type;
   typedef enum logic [2:0] {
      STMS_IDLE     = 3'b000,
      STMS_WYE      = 3'b001,
      STMS_DELTA    = 3'b010,
      STMS_LINE_RUN = 3'b011,
      STMS_PC_RUN   = 3'b100,
      STMS_TRIPPED  = 3'b101
   } stms_state_type;
endpackage

/* core/stms_sequencer.sv */
// Starter mode sequencer with AHB-Lite register slave
//
// Overview of operation
// - Wye-delta keeps protections except SCR, stack
// - Wye to delta below 85% current, 25% time
// - Full up-to-speed time forces delta transition
// - Start in wye-delta energizes run relay
// - Wye leaves on stop, timeout, condition, fault
// - Delta keeps run and at-speed relays on
// - Delta stays until stop or fault
// - Missing contactor feedback in time trips
// - Wye-delta ignores ramp, kick, decel settings
// - Wye-delta holds SCR gates disabled
// - Across-line energizes run relay on start
// - Across-line at full speed energizes at-speed
// - Across-line keeps protections, ignores ramp settings; here the code holds SCR, stack checks off (scr_protect_en low)
// - Across-line holds SCR gates disabled
// - Phase control energizes run relay on start
// - Phase control fires from analog input, open loop
// - Zero reference none, full reference full
// - Offset and span applied to raw input
// - Phase control ignores ramp, kick, decel settings
//
// Our own choices: the register offsets and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
`include "stms_cfg.svh"

module stms_sequencer #(
   parameter int TICK_CYC = `STMS_TICK_CYC
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [11:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        start_cmd,
   input  wire logic        fault_in,
   input  wire logic        running_contactor_fb,
   input  wire logic        motor_full_speed,
   input  wire logic [15:0] ain_raw,
   output logic             run_relay,
   output logic             at_speed_output,
   output logic             scr_gate_enable,
   output logic      [15:0] firing_level,
   output logic             scr_protect_en,
   output logic             profile_en,
   output logic             single_phase_setting,
   output logic             trip_flag
);

   ////////////////////////////////////////////////////////////////////////
   // State record
   typedef struct packed {
      stms_pkg::stms_state_type state;
      logic [1:0]  mode;
      logic        fb_en;
      logic        fb_cfg;
      logic        one_phase;
      logic [15:0] speed_time;
      logic [15:0] fb_time;
      logic [15:0] flc;
      logic [15:0] offset;
      logic [15:0] span;
      logic [15:0] meas;
      logic [31:0] tick_cnt;
      logic [15:0] ms_cnt;
      logic [15:0] fb_cnt;
      logic        trip;
      logic        fb_wait;
      logic        wr_pend;
      logic        rd_pend;
      logic [11:0] addr;
      logic [31:0] rdata;
      logic [15:0] level;
   } stms_regs_type;

   stms_regs_type r;
   stms_regs_type next_r;

   logic        tick;
   logic [31:0] cur_lim;
   logic [31:0] time_lim;
   logic [31:0] scaled;
   logic [16:0] shifted;
   logic        cur_ok;
   logic        time_ok;
   logic        time_out;
   logic        fb_timeout;

   ////////////////////////////////////////////////////////////////////////
   // Read decode, shared by the data phase
   function automatic logic [31:0] read_word(input stms_regs_type s, input logic [11:0] a);
      logic [31:0] v;
      v = 32'h00000000;
      unique case (a)
         `STMS_ADDR_CTRL:     v = {27'h0, s.one_phase, s.fb_cfg, s.fb_en, s.mode};
         `STMS_ADDR_SPEED_TIME: v = {16'h0, s.speed_time};
         `STMS_ADDR_FB_TIME:  v = {16'h0, s.fb_time};
         `STMS_ADDR_FLC:      v = {16'h0, s.flc};
         `STMS_ADDR_AIN_CAL:  v = {s.span, s.offset};
         `STMS_ADDR_MEAS:     v = {16'h0, s.meas};
         `STMS_ADDR_STATUS:   v = {16'h0, s.ms_cnt[11:0], s.trip, s.state};
         `STMS_ADDR_REF:      v = {16'h0, s.level};
         default:             v = 32'h00000000;
      endcase
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Threshold arithmetic
   assign tick     = (r.tick_cnt == 32'(TICK_CYC - 1));
   assign cur_lim  = 32'(r.flc) * 32'(`STMS_CUR_PCT);
   assign time_lim = 32'(r.speed_time) * 32'(`STMS_TIME_PCT);
   assign cur_ok   = (32'(r.meas) * 32'h00000064) < cur_lim;
   assign time_ok  = (32'(r.ms_cnt) * 32'h00000064) > time_lim;
   assign time_out = (r.ms_cnt >= r.speed_time);
   assign fb_timeout = r.fb_wait && (r.fb_cnt >= r.fb_time);
   // Offset then span (span 1024 = unity), clipped to 0..FFFF
   assign shifted  = (ain_raw > r.offset) ? {1'b0, ain_raw - r.offset} : 17'h00000;
   assign scaled   = (32'(shifted) * 32'(r.span)) >> 10;

   ////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      next_r = r;
      next_r.tick_cnt = tick ? 32'h00000000 : r.tick_cnt + 32'h00000001;
      // AHB-Lite address phase capture
      next_r.wr_pend = 1'b0;
      next_r.rd_pend = 1'b0;
      if (hsel && hready && htrans[1]) begin
         next_r.addr    = {haddr[11:2], 2'b00};
         next_r.wr_pend = hwrite;
         next_r.rd_pend = !hwrite;
      end
      if (r.rd_pend) begin
         next_r.rdata = read_word(r, r.addr);
      end
      if (r.wr_pend) begin
         unique case (r.addr)
            `STMS_ADDR_CTRL: begin
               next_r.mode   = hwdata[`STMS_CTRL_MODE_LSB +: 2];
               next_r.fb_en  = hwdata[`STMS_CTRL_FB_EN];
               next_r.fb_cfg = hwdata[`STMS_CTRL_FB_CFG];
               next_r.one_phase = hwdata[`STMS_CTRL_ONE_PHASE];
            end
            `STMS_ADDR_SPEED_TIME: next_r.speed_time = hwdata[15:0];
            `STMS_ADDR_FB_TIME:  next_r.fb_time  = hwdata[15:0];
            `STMS_ADDR_FLC:      next_r.flc      = hwdata[15:0];
            `STMS_ADDR_AIN_CAL: begin
               next_r.offset = hwdata[15:0];
               next_r.span   = hwdata[31:16];
            end
            `STMS_ADDR_MEAS:     next_r.meas     = hwdata[15:0];
            `STMS_ADDR_STATUS:   next_r.trip     = 1'b0;
            default: ;
         endcase
      end
      // Millisecond timers
      if (tick && r.ms_cnt != 16'hFFFF) begin
         next_r.ms_cnt = r.ms_cnt + 16'h0001;
      end
      if (tick && r.fb_wait && r.fb_cnt != 16'hFFFF) begin
         next_r.fb_cnt = r.fb_cnt + 16'h0001;
      end
      next_r.level = 16'h0000;
      unique case (r.state)
         stms_pkg::STMS_IDLE: begin
            next_r.ms_cnt  = 16'h0000;
            next_r.fb_cnt  = 16'h0000;
            next_r.fb_wait = 1'b0;
            if (start_cmd && !fault_in && !r.trip) begin
               unique case (r.mode)
                  stms_pkg::STMS_MODE_WYE_DELTA: next_r.state = stms_pkg::STMS_WYE;
                  stms_pkg::STMS_MODE_ACROSS:    next_r.state = stms_pkg::STMS_LINE_RUN;
                  stms_pkg::STMS_MODE_PHASE:     next_r.state = stms_pkg::STMS_PC_RUN;
                  default:                       next_r.state = stms_pkg::STMS_IDLE;
               endcase
            end
         end
         stms_pkg::STMS_WYE: begin
            if (fault_in) begin
               next_r.state = stms_pkg::STMS_TRIPPED;
            end else if (!start_cmd) begin
               next_r.state = stms_pkg::STMS_IDLE;
            end else if (time_out || (cur_ok && time_ok)) begin
               next_r.state   = stms_pkg::STMS_DELTA;
               next_r.fb_wait = r.fb_en && r.fb_cfg;
               next_r.fb_cnt  = 16'h0000;
            end
         end
         stms_pkg::STMS_DELTA: begin
            if (r.fb_wait && running_contactor_fb) begin
               next_r.fb_wait = 1'b0;
            end
            if (fault_in || (fb_timeout && !running_contactor_fb)) begin
               next_r.state = stms_pkg::STMS_TRIPPED;
            end else if (!start_cmd) begin
               next_r.state = stms_pkg::STMS_IDLE;
            end
         end
         stms_pkg::STMS_LINE_RUN, stms_pkg::STMS_PC_RUN: begin
            if (r.state == stms_pkg::STMS_PC_RUN) begin
               // Open loop: level follows scaled reference only
               next_r.level = (scaled > 32'h0000FFFF) ? 16'hFFFF : scaled[15:0];
            end
            if (fault_in) begin
               next_r.state = stms_pkg::STMS_TRIPPED;
            end else if (!start_cmd) begin
               next_r.state = stms_pkg::STMS_IDLE;
            end
         end
         stms_pkg::STMS_TRIPPED: begin
            next_r.fb_wait = 1'b0;
            next_r.trip    = 1'b1;
            if (!start_cmd && !fault_in) begin
               next_r.state = stms_pkg::STMS_IDLE;
            end
         end
         default: next_r.state = stms_pkg::STMS_IDLE;
      endcase
      // Latching trip: a new trip wins over a software clear
      if (r.state != stms_pkg::STMS_TRIPPED && next_r.state == stms_pkg::STMS_TRIPPED) begin
         next_r.trip = 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         r          <= '0;
         r.state    <= stms_pkg::STMS_IDLE;
         r.speed_time <= `STMS_SPEED_TIME_RST;
         r.fb_time  <= `STMS_FB_TIME_RST;
         r.span     <= `STMS_SPAN_RST;
      end else begin
         r <= next_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   // Reads insert one wait state so that hrdata comes from a register
   assign hreadyout = !r.rd_pend;
   assign hresp     = 1'b0;
   assign hrdata    = r.rdata;
   assign run_relay = (r.state == stms_pkg::STMS_WYE) ||
                      (r.state == stms_pkg::STMS_DELTA) ||
                      (r.state == stms_pkg::STMS_LINE_RUN) ||
                      (r.state == stms_pkg::STMS_PC_RUN);
   assign at_speed_output = (r.state == stms_pkg::STMS_DELTA) ||
                            (r.state == stms_pkg::STMS_LINE_RUN && motor_full_speed);
   assign scr_gate_enable = (r.state == stms_pkg::STMS_PC_RUN);
   assign firing_level    = r.level;
   // SCR and stack checks only in soft-start and phase control modes
   assign scr_protect_en  = (r.mode == stms_pkg::STMS_MODE_SOFT) ||
                            (r.mode == stms_pkg::STMS_MODE_PHASE);
   // Ramp, kick and decel only in soft-start mode
   assign profile_en = (r.mode == stms_pkg::STMS_MODE_SOFT);
   assign single_phase_setting = r.one_phase;
   assign trip_flag = r.trip;

   ////////////////////////////////////////////////////////////////////////
   // Assertions
   property p_gates_off_relay_modes;
      @(posedge hclk) disable iff (!hresetn)
      (r.mode != stms_pkg::STMS_MODE_PHASE) |-> !scr_gate_enable;
   endproperty
   a_gates_off_relay_modes: assert property (p_gates_off_relay_modes)
      else $error("SCR gates on outside phase control");

   property p_start_wye;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_IDLE && start_cmd && !fault_in && !r.trip &&
       r.mode == stms_pkg::STMS_MODE_WYE_DELTA) |=> run_relay && !at_speed_output;
   endproperty
   a_start_wye: assert property (p_start_wye)
      else $error("Wye start did not energize run relay");

   property p_delta_both;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_DELTA) |-> run_relay && at_speed_output;
   endproperty
   a_delta_both: assert property (p_delta_both)
      else $error("Delta without both relays");

   property p_timeout_delta;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_WYE && start_cmd && !fault_in && time_out)
      |=> r.state == stms_pkg::STMS_DELTA;
   endproperty
   a_timeout_delta: assert property (p_timeout_delta)
      else $error("No delta at up-to-speed timeout");

   property p_early_delta;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_WYE && start_cmd && !fault_in && !time_out &&
       !(cur_ok && time_ok)) |=> r.state == stms_pkg::STMS_WYE;
   endproperty
   a_early_delta: assert property (p_early_delta)
      else $error("Left wye without cause");

   property p_stop_drops;
      @(posedge hclk) disable iff (!hresetn)
      (run_relay && !start_cmd && !fault_in) |=> !run_relay && !at_speed_output;
   endproperty
   a_stop_drops: assert property (p_stop_drops)
      else $error("Relays held after stop");

   property p_fb_trip;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_DELTA && fb_timeout && !running_contactor_fb)
      |=> trip_flag && !run_relay;
   endproperty
   a_fb_trip: assert property (p_fb_trip)
      else $error("Feedback timeout did not trip");

   property p_pc_zero;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_PC_RUN && $stable(r.state) && ain_raw <= r.offset) |=>
      (firing_level == 16'h0000 || !$stable(ain_raw));
   endproperty
   a_pc_zero: assert property (p_pc_zero)
      else $error("Output at zero reference");

   property p_profile_off;
      @(posedge hclk) disable iff (!hresetn)
      (r.mode != stms_pkg::STMS_MODE_SOFT) |-> !profile_en;
   endproperty
   a_profile_off: assert property (p_profile_off)
      else $error("Profile active outside soft start");

   property p_line_start;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_IDLE && start_cmd && !fault_in && !r.trip &&
       r.mode == stms_pkg::STMS_MODE_ACROSS) |=> run_relay && !scr_gate_enable;
   endproperty
   a_line_start: assert property (p_line_start)
      else $error("Across-line start did not energize run relay");

   property p_pc_start;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_IDLE && start_cmd && !fault_in && !r.trip &&
       r.mode == stms_pkg::STMS_MODE_PHASE) |=> run_relay && scr_gate_enable;
   endproperty
   a_pc_start: assert property (p_pc_start)
      else $error("Phase control start did not energize run relay");

   property p_delta_hold;
      @(posedge hclk) disable iff (!hresetn)
      (r.state == stms_pkg::STMS_DELTA && start_cmd && !fault_in &&
       !(fb_timeout && !running_contactor_fb)) |=> r.state == stms_pkg::STMS_DELTA;
   endproperty
   a_delta_hold: assert property (p_delta_hold)
      else $error("Left delta without stop or fault");

   property p_fault_trip;
      @(posedge hclk) disable iff (!hresetn)
      (run_relay && fault_in) |=> trip_flag && !run_relay && !at_speed_output;
   endproperty
   a_fault_trip: assert property (p_fault_trip)
      else $error("Fault did not drop relays");

   property p_level_off;
      @(posedge hclk) disable iff (!hresetn)
      (r.state != stms_pkg::STMS_PC_RUN) |=> firing_level == 16'h0000;
   endproperty
   a_level_off: assert property (p_level_off)
      else $error("Firing level outside phase control");

endmodule // stms_sequencer

/* sim/stms_contactor_model.sv */
// Running contactor model answering the run and at-speed relays
`timescale 1ns/100ps

module stms_contactor_model #(
   parameter int PULL_CYC = 3
) (
   input  wire logic hclk,
   input  wire logic hresetn,
   input  wire logic run_relay,
   input  wire logic at_speed_output,
   input  wire logic close_ok,
   output logic      running_contactor_fb
);
   int cnt;

   // Closes a few cycles after both relays pull in, unless stuck open
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= 0;
         running_contactor_fb <= 1'b0;
      end else if (run_relay && at_speed_output && close_ok) begin
         if (cnt < PULL_CYC) begin
            cnt <= cnt + 1;
         end
         running_contactor_fb <= (cnt >= PULL_CYC);
      end else begin
         cnt <= 0;
         running_contactor_fb <= 1'b0;
      end
   end
endmodule // stms_contactor_model

/* sim/tb_starter_mode_sequencer.sv */
// Self-checking testbench of the starter mode sequencer
`timescale 1ns/100ps
`include "stms_cfg.svh"
`define TB_CHK(nm, exp, got) begin checks_done++; if ((got) !== (exp)) begin mismatches++; \
   $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module tb_starter_mode_sequencer;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        hsel = 1'b0;
   logic [11:0] haddr = 12'h000;
   logic [1:0]  htrans = 2'b00;
   logic        hwrite = 1'b0;
   logic [2:0]  hsize = 3'b010;
   logic [31:0] hwdata = 32'h00000000;
   logic        hready;
   logic [31:0] hrdata;
   logic        hresp;
   logic        start_cmd = 1'b0;
   logic        fault_in = 1'b0;
   logic        close_ok = 1'b1;
   logic        fb;
   logic        motor_full_speed = 1'b0;
   logic [15:0] ain_raw = 16'h0000;
   logic        run_relay;
   logic        at_speed_output;
   logic        scr_gate_enable;
   logic [15:0] firing_level;
   logic        scr_protect_en;
   logic        profile_en;
   logic        single_phase_setting;
   logic        trip_flag;
   logic [31:0] rd;
   int          mismatches = 0;
   int          checks_done = 0;

   // Design, its contactor, and the clock
   stms_sequencer #(.TICK_CYC(4)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hrdata(hrdata), .hreadyout(hready), .hresp(hresp),
      .start_cmd(start_cmd), .fault_in(fault_in), .running_contactor_fb(fb),
      .motor_full_speed(motor_full_speed), .ain_raw(ain_raw), .run_relay(run_relay),
      .at_speed_output(at_speed_output), .scr_gate_enable(scr_gate_enable),
      .firing_level(firing_level), .scr_protect_en(scr_protect_en), .profile_en(profile_en),
      .single_phase_setting(single_phase_setting), .trip_flag(trip_flag));
   stms_contactor_model cm (.hclk(hclk), .hresetn(hresetn), .run_relay(run_relay),
      .at_speed_output(at_speed_output), .close_ok(close_ok), .running_contactor_fb(fb));
   initial begin
      forever #2.5 hclk = ~hclk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Bus and timing helpers
   task automatic tick(input int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic ahb_addr(input logic [11:0] a, input logic w);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'b10;
      hwrite <= w;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
   endtask
   task automatic ahb_write(input logic [11:0] a, input logic [31:0] d);
      ahb_addr(a, 1'b1);
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
   task automatic ahb_read(input logic [11:0] a, output logic [31:0] d);
      ahb_addr(a, 1'b0);
      do @(posedge hclk); while (hready !== 1'b1);
      d = hrdata;
   endtask
   task automatic set_start(input logic v);
      @(posedge hclk);
      start_cmd <= v;
      tick(1);
   endtask
   // Cycles until the at-speed relay pulls in must fall in lo..hi
   task automatic wait_speed(input int lo, input int hi, input string nm);
      int n;
      n = 0;
      while (at_speed_output !== 1'b1 && n < 300) begin
         tick(1);
         n++;
      end
      `TB_CHK(nm, 1'b1, (n >= lo && n <= hi))
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset_vals();
      ahb_read(`STMS_ADDR_SPEED_TIME, rd);
      `TB_CHK("speed_rst", 32'h00002710, rd)
      `TB_CHK("resp", 1'b0, hresp)
      ahb_read(`STMS_ADDR_FB_TIME, rd);
      `TB_CHK("fb_rst", 32'h000001F4, rd)
      ahb_read(`STMS_ADDR_AIN_CAL, rd);
      `TB_CHK("cal_rst", 32'h04000000, rd)
      ahb_write(12'h020, 32'hFFFFFFFF);
      ahb_read(12'h020, rd);
      `TB_CHK("unmapped", 32'h00000000, rd)
   endtask
   task automatic t_wye(input logic [31:0] meas, input int lo, input int hi);
      ahb_write(`STMS_ADDR_CTRL, 32'h00000000);
      ahb_write(`STMS_ADDR_SPEED_TIME, 32'h00000014);
      ahb_write(`STMS_ADDR_FLC, 32'h00000064);
      ahb_write(`STMS_ADDR_MEAS, meas);
      set_start(1'b1);
      `TB_CHK("wye_run", 1'b1, run_relay)
      `TB_CHK("wye_spd", 1'b0, at_speed_output)
      `TB_CHK("wye_gate", 1'b0, scr_gate_enable)
      `TB_CHK("wye_prot", 1'b0, scr_protect_en)
      `TB_CHK("wye_prof", 1'b0, profile_en)
      wait_speed(lo, hi, "wye_to_delta");
      tick(20);
      `TB_CHK("delta_run", 1'b1, run_relay)
      `TB_CHK("delta_spd", 1'b1, at_speed_output)
   endtask
   task automatic t_wye_delta();
      t_wye(32'h00000055, 70, 95);
      set_start(1'b0);
      `TB_CHK("stop_run", 1'b0, run_relay)
      `TB_CHK("stop_spd", 1'b0, at_speed_output)
      t_wye(32'h00000032, 18, 34);
      @(posedge hclk);
      fault_in <= 1'b1;
      tick(2);
      `TB_CHK("fault_trip", 1'b1, trip_flag)
      `TB_CHK("fault_run", 1'b0, run_relay)
      `TB_CHK("fault_spd", 1'b0, at_speed_output)
      clear_trip();
   endtask
   task automatic clear_trip();
      @(posedge hclk);
      start_cmd <= 1'b0;
      fault_in <= 1'b0;
      tick(2);
      ahb_write(`STMS_ADDR_STATUS, 32'h00000000);
      ahb_read(`STMS_ADDR_STATUS, rd);
      `TB_CHK("trip_clear", 1'b0, rd[3])
   endtask
   task automatic t_feedback(input logic ok);
      int n;
      close_ok <= ok;
      ahb_write(`STMS_ADDR_CTRL, 32'h0000000C);
      // Current at 85% of full load, so only the timeout moves to delta
      ahb_write(`STMS_ADDR_MEAS, 32'h00000055);
      ahb_write(`STMS_ADDR_SPEED_TIME, 32'h00000004);
      ahb_write(`STMS_ADDR_FB_TIME, 32'h00000003);
      set_start(1'b1);
      wait_speed(10, 24, "fb_delta");
      n = 0;
      while (trip_flag !== 1'b1 && n < 60) begin
         tick(1);
         n++;
      end
      `TB_CHK("fb_trip", !ok, trip_flag)
      `TB_CHK("fb_run", ok, run_relay)
      clear_trip();
   endtask
   task automatic t_across();
      ahb_write(`STMS_ADDR_CTRL, 32'h00000001);
      set_start(1'b1);
      `TB_CHK("line_run", 1'b1, run_relay)
      `TB_CHK("line_gate", 1'b0, scr_gate_enable)
      `TB_CHK("line_prot", 1'b0, scr_protect_en)
      `TB_CHK("line_prof", 1'b0, profile_en)
      tick(5);
      `TB_CHK("line_slow", 1'b0, at_speed_output)
      @(posedge hclk);
      motor_full_speed <= 1'b1;
      tick(1);
      `TB_CHK("line_spd", 1'b1, at_speed_output)
      set_start(1'b0);
      `TB_CHK("line_stop", 1'b0, run_relay)
      motor_full_speed <= 1'b0;
   endtask
   task automatic t_phase();
      logic [15:0] raw [3];
      logic [15:0] lvl [3];
      raw = '{16'h0080, 16'h1100, 16'hFFFF};
      lvl = '{16'h0000, 16'h2000, 16'hFFFF};
      ahb_write(`STMS_ADDR_CTRL, 32'h00000012);
      ahb_write(`STMS_ADDR_AIN_CAL, 32'h08000100);
      set_start(1'b1);
      `TB_CHK("pc_run", 1'b1, run_relay)
      `TB_CHK("pc_gate", 1'b1, scr_gate_enable)
      `TB_CHK("pc_prof", 1'b0, profile_en)
      `TB_CHK("pc_sph", 1'b1, single_phase_setting)
      `TB_CHK("pc_prot", 1'b1, scr_protect_en)
      for (int i = 0; i < 3; i++) begin
         @(posedge hclk);
         ain_raw <= raw[i];
         tick(3);
         `TB_CHK("pc_level", lvl[i], firing_level)
         ahb_read(`STMS_ADDR_REF, rd);
         `TB_CHK("pc_ref", {16'h0000, lvl[i]}, rd)
      end
      set_start(1'b0);
      // Soft-start code: profile on, no relay start in this block
      ahb_write(`STMS_ADDR_CTRL, 32'h00000003);
      tick(1);
      `TB_CHK("soft_prof", 1'b1, profile_en)
      set_start(1'b1);
      `TB_CHK("soft_idle", 1'b0, run_relay)
      set_start(1'b0);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Verdict, watchdog and main sequence
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   initial begin
      #100000;
      mismatches++;
      print_verdict();
   end
   initial begin
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      tick(1);
      `TB_CHK("rst_run", 1'b0, run_relay)
      t_reset_vals();
      t_wye_delta();
      t_feedback(1'b0);
      t_feedback(1'b1);
      t_across();
      t_phase();
      print_verdict();
   end
endmodule // tb_starter_mode_sequencer
